/* core/interval_timer.sv */
/*
 Interval timer in seconds or minutes, paced by the RTC seconds tick.
 Assumes sec_tick_in is a one-cycle pulse on clk_in.
*/
`timescale 1ns/1ps
`include "mission_cfg.svh"

module interval_timer (
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// Control
	input wire logic load_in,
	input wire logic run_in,
	input wire logic unit_min_in,
	input wire logic [`TIMER_W-1:0] period_in,
	input wire logic sec_tick_in,
	// Result
	output logic expire_out
);

	logic [`TIMER_W-1:0] cnt;
	logic [5:0] pre;
	logic [`TIMER_W-1:0] next_cnt;
	logic [5:0] next_pre;
	logic next_expire;
	logic unit_done;

	// ==========================================================
	// Countdown
	// ==========================================================
	always_comb begin
		next_cnt = cnt;
		next_pre = pre;
		next_expire = 1'b0;
		unit_done = 1'b0;
		if (load_in) begin
			next_cnt = period_in;
			next_pre = 6'h00;
		end else if (run_in && sec_tick_in) begin
			if (!unit_min_in || pre == `SECS_PER_MIN) begin
				unit_done = 1'b1;
				next_pre = 6'h00;
			end else begin
				next_pre = pre + 6'h01;
			end
			if (unit_done) begin
				// Zero period behaves as one unit
				if (cnt <= `TIMER_W'h0001) begin
					next_expire = 1'b1;
					next_cnt = period_in;
				end else begin
					next_cnt = cnt - `TIMER_W'h0001;
				end
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			cnt <= `TIMER_W'h0000;
			pre <= 6'h00;
			expire_out <= 1'b0;
		end else begin
			cnt <= next_cnt;
			pre <= next_pre;
			expire_out <= next_expire;
		end
	end

endmodule

/* core/mission_cfg.svh */
/*
 Constants for the mission control and transfer status logic.
 Assumes inclusion by bare name from files under core/.
*/
`ifndef MISSION_CFG_SVH
`define MISSION_CFG_SVH

// ==========================================================
// Timing
// ==========================================================
`define SECS_PER_MIN 6'd59
`define RATE_W 14
`define RATE_MIN 14'h0001
`define TIMER_W 16

// ==========================================================
// Datalog and counters
// ==========================================================
`define LOG_ADDR_W 13
`define LOG_LAST 13'h1fff
`define COUNT_W 24

// ==========================================================
// Address map
// ==========================================================
`define GP_LAST 16'h01ff
`define PW_FIRST 16'h0228
`define PW_LAST 16'h0237
`define READ_MASKED 8'h00

// ==========================================================
// Ending offset / status byte
// ==========================================================
`define EO_W 5
`define EO_FULL 5'h1f
`define ES_PF_BIT 5
`define ES_ZERO_BIT 6
`define ES_AA_BIT 7

// ==========================================================
// Alarm enables and flags: tl, th, dl, dh
// ==========================================================
`define ALARM_W 4

`endif

/* core/mission_control.sv */
/*
 Mission control: start modes, sample timing, counters, rollover,
 alarm match for conditional search, access gating, transfer status.
 Assumes one-cycle command strobes
 and a one-cycle RTC seconds tick, all on clk_in.
*/
`timescale 1ns/1ps
`include "mission_cfg.svh"

// Contract
// - Enabled alarm seen: answer conditional search
// - Rollover wraps log; otherwise stop when full
// - Sample interval is 14-bit, 1 to 16383
// - Unit select: seconds at 1, minutes 0
// - Start sets active flag, clears cleared flag
// - Delay start: wait, stamp, log first
// - Delay start: each entry bumps both counters
// - Alarm start: wakes bump device counter only
// - Alarm sample logs; stamp one period later
// - General memory writable during a mission
// - Reads always allowed; passwords read zero
// - Master loads target address for transfer
// - Status byte read only, counts and reports
// - Low five bits hold ending offset
// - Copy runs only with ending offset 1Fh
// - Partial flag on non-byte bit count
// - Status bit six reads zero
// - Target low bits set scratchpad start offset
// - Copy sets authorization; new write clears it
module mission_control (
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// Mission setup
	input wire logic rollover_enable_in,
	input wire logic high_speed_sampling_select_in,
	input wire logic [`RATE_W-1:0] sample_rate_in,
	input wire logic [`TIMER_W-1:0] start_delay_in,
	input wire logic start_on_temp_alarm_in,
	input wire logic temperature_logging_enable_in,
	input wire logic [`ALARM_W-1:0] alarm_enable_in,
	// Commands
	input wire logic start_mission_in,
	input wire logic stop_mission_in,
	input wire logic clear_memory_in,
	// Timebase and alarm events
	input wire logic sec_tick_in,
	input wire logic [`ALARM_W-1:0] alarm_event_in,
	// Memory access
	input wire logic [15:0] mem_addr_in,
	input wire logic mem_wr_req_in,
	input wire logic [7:0] mem_rd_data_in,
	// Transfer status strobes
	input wire logic ta_low_wr_in,
	input wire logic ta_high_wr_in,
	input wire logic [7:0] ta_data_in,
	input wire logic sp_start_in,
	input wire logic sp_byte_in,
	input wire logic sp_end_in,
	input wire logic sp_partial_in,
	input wire logic copy_req_in,
	// Mission status
	output logic mission_active_flag_out,
	output logic memory_cleared_flag_out,
	output logic [`ALARM_W-1:0] alarm_flags_out,
	output logic cond_search_match_out,
	// Logging actions
	output logic wake_measure_out,
	output logic log_write_out,
	output logic [`LOG_ADDR_W-1:0] log_addr_out,
	output logic stamp_write_out,
	output logic [`COUNT_W-1:0] mission_samples_out,
	output logic [`COUNT_W-1:0] device_samples_out,
	// Memory access answers
	output logic mem_wr_allow_out,
	output logic [7:0] mem_rd_data_out,
	// Transfer status
	output logic [7:0] target_addr_low_out,
	output logic [7:0] target_addr_high_out,
	output logic [7:0] ending_offset_status_out,
	output logic [`EO_W-1:0] sp_offset_out,
	output logic copy_go_out,
	output logic copy_refused_out
);

	mission_pkg::mission_state_e state, next_state;
	logic next_mip, next_memory_cleared_flag;
	logic [`ALARM_W-1:0] next_alarm_flags;
	logic next_match, next_wake, next_log, next_stamp;
	logic [`LOG_ADDR_W-1:0] next_log_addr;
	logic [`COUNT_W-1:0] next_msc, next_dsc;
	logic next_wr_allow;
	logic [7:0] next_rd_data;
	logic delay_load, rate_load, delay_run, rate_run;
	logic delay_exp, rate_exp;
	logic [`TIMER_W-1:0] rate_period;
	logic temp_alarm_now;
	logic [7:0] ta_low, ta_high, es_byte;
	logic [`EO_W-1:0] sp_off;
	logic cp_go, cp_ref;

	// Counter step shared by both sample counters
	function automatic logic [`COUNT_W-1:0] bump(input logic [`COUNT_W-1:0] v);
		bump = v + `COUNT_W'h000001;
	endfunction

	// Address window test used by both access paths
	function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	// ==========================================================
	// Timers
	// ==========================================================
	// zero is outside range, treated as one
	always_comb begin
		rate_period = {{(`TIMER_W-`RATE_W){1'b0}}, sample_rate_in};
		if (sample_rate_in == `RATE_W'h0000) begin
			rate_period = {{(`TIMER_W-`RATE_W){1'b0}}, `RATE_MIN};
		end
	end

	interval_timer u_delay_timer (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.load_in(delay_load),
		.run_in(delay_run),
		.unit_min_in(1'b1),
		.period_in(start_delay_in),
		.sec_tick_in(sec_tick_in),
		.expire_out(delay_exp)
	);

	// unit select picks seconds or minutes
	interval_timer u_rate_timer (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.load_in(rate_load),
		.run_in(rate_run),
		.unit_min_in(!high_speed_sampling_select_in),
		.period_in(rate_period),
		.sec_tick_in(sec_tick_in),
		.expire_out(rate_exp)
	);

	// ==========================================================
	// Transfer status
	// ==========================================================
	transfer_status u_status (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.ta_low_wr_in(ta_low_wr_in),
		.ta_high_wr_in(ta_high_wr_in),
		.ta_data_in(ta_data_in),
		.sp_start_in(sp_start_in),
		.sp_byte_in(sp_byte_in),
		.sp_end_in(sp_end_in),
		.sp_partial_in(sp_partial_in),
		.copy_req_in(copy_req_in),
		.target_addr_low(ta_low),
		.target_addr_high(ta_high),
		.es_byte(es_byte),
		.sp_offset(sp_off),
		.copy_go(cp_go),
		.copy_refused(cp_ref)
	);

	// ==========================================================
	// Mission sequencing
	// ==========================================================
	// Low and high temperature alarm events only
	assign temp_alarm_now = |alarm_event_in[1:0];

	always_comb begin
		next_state = state;
		next_mip = mission_active_flag_out;
		next_memory_cleared_flag = memory_cleared_flag_out;
		next_wake = 1'b0;
		next_log = 1'b0;
		next_stamp = 1'b0;
		next_log_addr = log_addr_out;
		next_msc = mission_samples_out;
		next_dsc = device_samples_out;
		delay_load = 1'b0;
		rate_load = 1'b0;
		delay_run = (state == mission_pkg::st_delay);
		rate_run = (state == mission_pkg::st_wait_alarm) ||
			(state == mission_pkg::st_stamp_pending) ||
			(state == mission_pkg::st_logging);
		case (state)
			mission_pkg::st_idle: begin
				if (start_mission_in) begin
					next_mip = 1'b1;
					next_memory_cleared_flag = 1'b0;
					next_log_addr = `LOG_ADDR_W'h0000;
					delay_load = 1'b1;
					next_state = mission_pkg::st_delay;
				end
			end
			mission_pkg::st_delay: begin
				// A zero delay starts on the first tick
				if (delay_exp || (start_delay_in == `TIMER_W'h0000 && sec_tick_in)) begin
					rate_load = 1'b1;
					if (start_on_temp_alarm_in && temperature_logging_enable_in) begin
						next_state = mission_pkg::st_wait_alarm;
					end else begin
						next_stamp = 1'b1;
						next_log = 1'b1;
						next_msc = bump(mission_samples_out);
						next_dsc = bump(device_samples_out);
						next_state = mission_pkg::st_logging;
					end
				end
			end
			mission_pkg::st_wait_alarm: begin
				if (rate_exp) begin
					next_wake = 1'b1;
					next_dsc = bump(device_samples_out);
					next_state = mission_pkg::st_wait_alarm;
				end
				if (temp_alarm_now) begin
					// alarm sample logs, mission count held
					next_log = 1'b1;
					rate_load = 1'b1;
					next_state = mission_pkg::st_stamp_pending;
				end
			end
			mission_pkg::st_stamp_pending: begin
				if (rate_exp) begin
					next_stamp = 1'b1;
					next_wake = 1'b1;
					next_log = 1'b1;
					next_msc = bump(mission_samples_out);
					next_dsc = bump(device_samples_out);
					next_state = mission_pkg::st_logging;
				end
			end
			mission_pkg::st_logging: begin
				if (rate_exp) begin
					next_wake = 1'b1;
					next_log = 1'b1;
					next_msc = bump(mission_samples_out);
					next_dsc = bump(device_samples_out);
				end
			end
			mission_pkg::st_full: begin
				next_state = mission_pkg::st_full;
			end
			default: begin
				next_state = mission_pkg::st_idle;
			end
		endcase
		// Address advances after each written entry
		if (log_write_out) begin
			if (log_addr_out == `LOG_LAST) begin
				if (rollover_enable_in) begin
					next_log_addr = `LOG_ADDR_W'h0000;
				end else begin
					next_state = mission_pkg::st_full;
					next_log = 1'b0;
				end
			end else begin
				next_log_addr = log_addr_out + `LOG_ADDR_W'h0001;
			end
		end
		if (state == mission_pkg::st_full) begin
			next_log = 1'b0;
			next_wake = 1'b0;
			next_stamp = 1'b0;
			next_msc = mission_samples_out;
			next_dsc = device_samples_out;
		end
		if (stop_mission_in && mission_active_flag_out) begin
			next_mip = 1'b0;
			next_state = mission_pkg::st_idle;
			next_log = 1'b0;
		end
		// Clear only while idle; wipes what a new mission needs
		if (clear_memory_in && !mission_active_flag_out) begin
			next_memory_cleared_flag = 1'b1;
			next_msc = `COUNT_W'h000000;
			next_log_addr = `LOG_ADDR_W'h0000;
		end
	end

	// ==========================================================
	// Alarms and memory access
	// ==========================================================
	always_comb begin
		next_alarm_flags = alarm_flags_out;
		if (clear_memory_in && !mission_active_flag_out) begin
			next_alarm_flags = {`ALARM_W{1'b0}};
		end
		// Set beats clear in the same cycle
		if (mission_active_flag_out) begin
			next_alarm_flags = next_alarm_flags | (alarm_event_in & alarm_enable_in);
		end
		// enabled alarm seen makes device answer
		next_match = |(next_alarm_flags & alarm_enable_in);
		// general memory stays writable in mission
		next_wr_allow = mem_wr_req_in &&
			(!mission_active_flag_out || in_range(mem_addr_in, 16'h0000, `GP_LAST));
		next_rd_data = mem_rd_data_in;
		if (in_range(mem_addr_in, `PW_FIRST, `PW_LAST)) begin
			next_rd_data = `READ_MASKED;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			state <= mission_pkg::st_idle;
			mission_active_flag_out <= 1'b0;
			memory_cleared_flag_out <= 1'b0;
			alarm_flags_out <= {`ALARM_W{1'b0}};
			cond_search_match_out <= 1'b0;
			wake_measure_out <= 1'b0;
			log_write_out <= 1'b0;
			log_addr_out <= `LOG_ADDR_W'h0000;
			stamp_write_out <= 1'b0;
			mission_samples_out <= `COUNT_W'h000000;
			device_samples_out <= `COUNT_W'h000000;
			mem_wr_allow_out <= 1'b0;
			mem_rd_data_out <= 8'h00;
			target_addr_low_out <= 8'h00;
			target_addr_high_out <= 8'h00;
			ending_offset_status_out <= 8'h00;
			sp_offset_out <= `EO_W'h00;
			copy_go_out <= 1'b0;
			copy_refused_out <= 1'b0;
		end else begin
			state <= next_state;
			mission_active_flag_out <= next_mip;
			memory_cleared_flag_out <= next_memory_cleared_flag;
			alarm_flags_out <= next_alarm_flags;
			cond_search_match_out <= next_match;
			wake_measure_out <= next_wake;
			log_write_out <= next_log;
			log_addr_out <= next_log_addr;
			stamp_write_out <= next_stamp;
			mission_samples_out <= next_msc;
			device_samples_out <= next_dsc;
			mem_wr_allow_out <= next_wr_allow;
			mem_rd_data_out <= next_rd_data;
			target_addr_low_out <= ta_low;
			target_addr_high_out <= ta_high;
			ending_offset_status_out <= es_byte;
			sp_offset_out <= sp_off;
			copy_go_out <= cp_go;
			copy_refused_out <= cp_ref;
		end
	end

endmodule

/* core/mission_pkg.sv */
/*
 Types for the mission control logic.
 Assumes nothing of its surroundings.
*/
package mission_pkg;

	typedef enum logic [2:0] {
		st_idle,
		st_delay,
		st_wait_alarm,
		st_stamp_pending,
		st_logging,
		st_full
	} mission_state_e;

endpackage

/* core/transfer_status.sv */
/*
 Target address bytes and ending offset / status byte.
 Assumes the bus engine presents decoded, same-clock strobes.
*/
`timescale 1ns/1ps
`include "mission_cfg.svh"

module transfer_status (
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// Target address loads
	input wire logic ta_low_wr_in,
	input wire logic ta_high_wr_in,
	input wire logic [7:0] ta_data_in,
	// Scratchpad write
	input wire logic sp_start_in,
	input wire logic sp_byte_in,
	input wire logic sp_end_in,
	input wire logic sp_partial_in,
	// Copy
	input wire logic copy_req_in,
	// State
	output logic [7:0] target_addr_low,
	output logic [7:0] target_addr_high,
	output logic [7:0] es_byte,
	output logic [`EO_W-1:0] sp_offset,
	output logic copy_go,
	output logic copy_refused
);

	logic [`EO_W-1:0] eo;
	logic pf;
	logic aa;
	logic any_byte;
	logic [`EO_W-1:0] next_eo, next_off;
	logic [7:0] next_ta_low, next_ta_high;
	logic next_pf, next_aa, next_any, next_go, next_ref;

	// byte is read only, built here
	always_comb begin
		es_byte = 8'h00;
		es_byte[`EO_W-1:0] = eo;
		es_byte[`ES_PF_BIT] = pf;
		es_byte[`ES_ZERO_BIT] = 1'b0;
		es_byte[`ES_AA_BIT] = aa;
	end

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb begin
		next_ta_low = target_addr_low;
		next_ta_high = target_addr_high;
		next_eo = eo;
		next_pf = pf;
		next_aa = aa;
		next_off = sp_offset;
		next_any = any_byte;
		next_go = 1'b0;
		next_ref = 1'b0;
		if (ta_low_wr_in) begin
			next_ta_low = ta_data_in;
		end
		if (ta_high_wr_in) begin
			next_ta_high = ta_data_in;
		end
		if (sp_start_in) begin
			next_off = target_addr_low[`EO_W-1:0];
			next_eo = target_addr_low[`EO_W-1:0];
			next_pf = 1'b0;
			next_any = 1'b0;
			next_aa = 1'b0;
		end else if (sp_byte_in) begin
			// last byte written sets ending offset
			next_eo = sp_offset;
			next_any = 1'b1;
			if (sp_offset != `EO_FULL) begin
				next_off = sp_offset + `EO_W'h01;
			end
		end
		if (sp_end_in && sp_partial_in) begin
			next_pf = 1'b1;
		end
		if (copy_req_in) begin
			// copy only at full ending offset
			if (eo == `EO_FULL && any_byte) begin
				next_go = 1'b1;
				next_aa = 1'b1;
			end else begin
				next_ref = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			target_addr_low <= 8'h00;
			target_addr_high <= 8'h00;
			eo <= `EO_W'h00;
			pf <= 1'b0;
			aa <= 1'b0;
			sp_offset <= `EO_W'h00;
			any_byte <= 1'b0;
			copy_go <= 1'b0;
			copy_refused <= 1'b0;
		end else begin
			target_addr_low <= next_ta_low;
			target_addr_high <= next_ta_high;
			eo <= next_eo;
			pf <= next_pf;
			aa <= next_aa;
			sp_offset <= next_off;
			any_byte <= next_any;
			copy_go <= next_go;
			copy_refused <= next_ref;
		end
	end

endmodule

/* verif/bus_master_model.sv */
/*
 Behavioural bus master: decoded command strobes and the seconds tick.
 Assumes the bench calls its tasks just after a falling clock edge.
*/
`timescale 1ns/1ps

module bus_master_model (
	// Clock
	input wire logic clk_in,
	// Strobes toward the device
	output logic start_mission_out,
	output logic stop_mission_out,
	output logic clear_memory_out,
	output logic sec_tick_out,
	output logic ta_low_wr_out,
	output logic ta_high_wr_out,
	output logic sp_start_out,
	output logic sp_byte_out,
	output logic sp_end_out,
	output logic copy_req_out,
	// Qualifiers
	output logic [7:0] ta_data_out,
	output logic sp_partial_out
);
	logic [9:0] strobe = 10'h000;

	assign {copy_req_out, sp_end_out, sp_byte_out, sp_start_out, ta_high_wr_out} = strobe[9:5];
	assign {ta_low_wr_out, sec_tick_out, clear_memory_out} = strobe[4:2];
	assign {stop_mission_out, start_mission_out} = strobe[1:0];

	initial begin
		ta_data_out = 8'h00;
		sp_partial_out = 1'b0;
	end

	// One-cycle strobe on falling edges
	task automatic pulse(input int idx);
		@(negedge clk_in);
		strobe[idx] = 1'b1;
		@(negedge clk_in);
		strobe[idx] = 1'b0;
	endtask

	task automatic tick();
		pulse(3);
	endtask

	task automatic load_target(input logic [15:0] addr);
		ta_data_out = addr[7:0];
		pulse(4);
		ta_data_out = addr[15:8];
		pulse(5);
		// Released bus shows no stale byte
		ta_data_out = ~addr[15:8];
	endtask

	task automatic write_pad(input int n, input logic partial);
		pulse(6);
		repeat (n) pulse(7);
		sp_partial_out = partial;
		pulse(8);
		sp_partial_out = ~partial;
	endtask
endmodule

/* verif/mission_control_assertions.sv */
/*
 Checker on the ports of mission_control, bound by the statement at the foot.
 Assumes status two cycles and memory one cycle behind.
*/
`timescale 1ns/1ps
`include "mission_cfg.svh"

module mission_control_checker (
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// Watched inputs
	input wire logic start_mission_in,
	input wire logic [`ALARM_W-1:0] alarm_enable_in,
	input wire logic [15:0] mem_addr_in,
	input wire logic mem_wr_req_in,
	input wire logic [7:0] mem_rd_data_in,
	input wire logic ta_low_wr_in,
	input wire logic [7:0] ta_data_in,
	input wire logic sp_start_in,
	input wire logic sp_end_in,
	input wire logic sp_partial_in,
	// Watched outputs
	input wire logic mission_active_flag_out,
	input wire logic memory_cleared_flag_out,
	input wire logic [`ALARM_W-1:0] alarm_flags_out,
	input wire logic cond_search_match_out,
	input wire logic wake_measure_out,
	input wire logic [`COUNT_W-1:0] device_samples_out,
	input wire logic mem_wr_allow_out,
	input wire logic [7:0] mem_rd_data_out,
	input wire logic [7:0] target_addr_low_out,
	input wire logic [7:0] ending_offset_status_out,
	input wire logic copy_go_out
);
	wire logic pw_hit = (mem_addr_in >= 16'h0228) && (mem_addr_in <= 16'h0237);

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);

	// ==========================================================
	// Mission
	chk_start_flags: assert property (
		start_mission_in && !mission_active_flag_out
		|=> mission_active_flag_out && !memory_cleared_flag_out)
		else $error("start did not update mission flags");
	chk_wake_count: assert property (
		wake_measure_out |-> device_samples_out == $past(device_samples_out) + 24'h1)
		else $error("wake without device count step");
	chk_cond_search: assert property (
		(alarm_flags_out & alarm_enable_in) != 4'h0 |=> cond_search_match_out)
		else $error("enabled alarm not answering search");
	chk_gp_write: assert property (
		mem_wr_req_in && mem_addr_in <= 16'h01ff |=> mem_wr_allow_out)
		else $error("general memory write blocked");
	chk_read_mask: assert property (
		1'b1 |=> mem_rd_data_out == ($past(pw_hit) ? 8'h00 : $past(mem_rd_data_in)))
		else $error("read data wrong or password exposed");

	// ==========================================================
	// Transfer status
	chk_target_low: assert property (
		ta_low_wr_in |-> ##2 target_addr_low_out == $past(ta_data_in, 2))
		else $error("target low byte not loaded");
	chk_bit_six: assert property (
		ending_offset_status_out[6] == 1'b0)
		else $error("status bit six set");
	chk_copy_full: assert property (
		copy_go_out |-> ending_offset_status_out[4:0] == 5'h1f && ending_offset_status_out[7])
		else $error("copy ran without full offset or flag");
	chk_write_clears: assert property (
		sp_start_in |-> ##2 !ending_offset_status_out[7] && !ending_offset_status_out[5])
		else $error("new write left flags set");
	chk_partial_flag: assert property (
		sp_end_in |-> ##2 ending_offset_status_out[5] == $past(sp_partial_in, 2))
		else $error("partial flag wrong");

	cov_copy: cover property (copy_go_out);
	cov_wake: cover property (wake_measure_out);
	cov_search: cover property (cond_search_match_out);
endmodule

bind mission_control mission_control_checker chk_i (.*);

/* verif/test_mission_control.sv */
/*
 Self-checking bench for mission_control with a bus master model.
 Assumes the status and strobe latencies of the design.
*/
`timescale 1ns/1ps
`include "mission_cfg.svh"

module test_mission_control;
	typedef struct packed {logic [15:0] addr; logic wr; logic allow; logic [7:0] rd;} mem_row_s;

	// ==========================================================
	// Signals
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic rollover_enable_in = 1'b0;
	logic high_speed_sampling_select_in = 1'b1;
	logic [`RATE_W-1:0] sample_rate_in = 14'h0002;
	logic [`TIMER_W-1:0] start_delay_in = 16'h0000;
	logic start_on_temp_alarm_in = 1'b0;
	logic temperature_logging_enable_in = 1'b1;
	logic [`ALARM_W-1:0] alarm_enable_in = 4'h2;
	logic [`ALARM_W-1:0] alarm_event_in = 4'h0;
	logic [15:0] mem_addr_in = 16'h0000;
	logic mem_wr_req_in = 1'b0;
	logic [7:0] mem_rd_data_in = 8'h5a;
	logic start_mission_in, stop_mission_in, clear_memory_in, sec_tick_in;
	logic ta_low_wr_in, ta_high_wr_in, sp_start_in, sp_byte_in, sp_end_in;
	logic sp_partial_in, copy_req_in;
	logic [7:0] ta_data_in;
	logic mission_active_flag_out, memory_cleared_flag_out, cond_search_match_out;
	logic wake_measure_out, log_write_out, stamp_write_out, mem_wr_allow_out;
	logic copy_go_out, copy_refused_out;
	logic [`ALARM_W-1:0] alarm_flags_out;
	logic [`LOG_ADDR_W-1:0] log_addr_out;
	logic [`COUNT_W-1:0] mission_samples_out, device_samples_out;
	logic [7:0] mem_rd_data_out, target_addr_low_out, target_addr_high_out;
	logic [7:0] ending_offset_status_out;
	int n_mismatch = 0;
	int check_count = 0;
	// Accesses during a mission
	mem_row_s rows [7] = '{
		'{16'h0000, 1'b1, 1'b1, 8'h5a}, '{16'h01ff, 1'b1, 1'b1, 8'h5a},
		'{16'h0200, 1'b1, 1'b0, 8'h5a}, '{16'h0228, 1'b0, 1'b0, 8'h00},
		'{16'h0237, 1'b1, 1'b0, 8'h00}, '{16'h0227, 1'b0, 1'b0, 8'h5a},
		'{16'h0238, 1'b0, 1'b0, 8'h5a}};

	always #10 clk_in = ~clk_in;

	bus_master_model master (.clk_in, .start_mission_out(start_mission_in),
		.stop_mission_out(stop_mission_in), .clear_memory_out(clear_memory_in),
		.sec_tick_out(sec_tick_in), .ta_low_wr_out(ta_low_wr_in),
		.ta_high_wr_out(ta_high_wr_in), .sp_start_out(sp_start_in), .sp_byte_out(sp_byte_in),
		.sp_end_out(sp_end_in), .copy_req_out(copy_req_in), .ta_data_out(ta_data_in),
		.sp_partial_out(sp_partial_in));

	mission_control uut (.*, .sp_offset_out());

	// ==========================================================
	// Compare and closing tasks
	task automatic chk_bit(input string what, input logic exp, input logic got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic chk_val(input string what, input logic [23:0] exp, input logic [23:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(negedge clk_in);
	endtask

	task automatic close_out();
		$display("Checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Sequence
	initial begin
		settle(2);
		sys_rst_in = 1'b0;
		master.pulse(2);
		settle(2);
		chk_bit("memory_cleared", 1'b1, memory_cleared_flag_out);
		master.pulse(0);
		settle(1);
		chk_bit("mission_active", 1'b1, mission_active_flag_out);
		chk_bit("memory_cleared", 1'b0, memory_cleared_flag_out);
		foreach (rows[i]) begin
			@(negedge clk_in);
			mem_addr_in = rows[i].addr;
			mem_wr_req_in = rows[i].wr;
			@(negedge clk_in);
			chk_bit("write_allow", rows[i].allow, mem_wr_allow_out);
			chk_val("read_data", {16'h0, rows[i].rd}, {16'h0, mem_rd_data_out});
		end
		mem_wr_req_in = 1'b0;
		// Zero delay: first tick stamps and logs
		master.tick();
		chk_bit("stamp", 1'b1, stamp_write_out);
		chk_bit("log", 1'b1, log_write_out);
		chk_val("mission_count", 24'h1, mission_samples_out);
		chk_val("device_count", 24'h1, device_samples_out);
		master.tick();
		settle(2);
		chk_bit("log", 1'b0, log_write_out);
		master.tick();
		settle(1);
		chk_bit("log", 1'b1, log_write_out);
		chk_val("mission_count", 24'h2, mission_samples_out);
		chk_val("device_count", 24'h2, device_samples_out);
		@(negedge clk_in);
		alarm_event_in = 4'h2;
		@(negedge clk_in);
		alarm_event_in = 4'h0;
		settle(1);
		chk_bit("cond_search", 1'b1, cond_search_match_out);
		master.pulse(1);
		settle(1);
		chk_bit("mission_active", 1'b0, mission_active_flag_out);
		// Mid-page write: four bytes fill
		master.load_target(16'h013c);
		settle(2);
		chk_val("target", 24'h13c, {8'h0, target_addr_high_out, target_addr_low_out});
		master.write_pad(4, 1'b0);
		settle(2);
		chk_val("status", 24'h1f, {16'h0, ending_offset_status_out});
		master.pulse(9);
		settle(1);
		chk_bit("copy_go", 1'b1, copy_go_out);
		chk_val("status", 24'h9f, {16'h0, ending_offset_status_out});
		// Partial write: copy refused
		master.load_target(16'h0000);
		master.write_pad(2, 1'b1);
		settle(2);
		chk_val("status", 24'h21, {16'h0, ending_offset_status_out});
		master.pulse(9);
		settle(1);
		chk_bit("copy_refused", 1'b1, copy_refused_out);
		chk_bit("copy_go", 1'b0, copy_go_out);
		// Reset in mid-mission
		master.pulse(0);
		sys_rst_in = 1'b1;
		settle(2);
		chk_bit("mission_active", 1'b0, mission_active_flag_out);
		chk_val("status", 24'h0, {16'h0, ending_offset_status_out});
		chk_val("device_count", 24'h0, device_samples_out);
		sys_rst_in = 1'b0;
		// Alarm start: wakes count device only
		start_on_temp_alarm_in = 1'b1;
		sample_rate_in = 14'h0001;
		alarm_enable_in = 4'h1;
		master.pulse(0);
		master.tick();
		master.tick();
		settle(1);
		chk_val("device_count", 24'h1, device_samples_out);
		alarm_event_in = 4'h1;
		@(negedge clk_in);
		alarm_event_in = 4'h0;
		chk_bit("log", 1'b1, log_write_out);
		chk_val("mission_count", 24'h0, mission_samples_out);
		chk_bit("cond_search", 1'b1, cond_search_match_out);
		settle(2);
		close_out();
	end

	// About 3000 cycles
	initial begin
		repeat (3000) @(posedge clk_in);
		n_mismatch++;
		close_out();
	end
endmodule
